// >>> ursb_baud.sv
// Purpose: Baud divisor counter producing sixteen-per-bit ticks
// Assumes: Divisor may change at any time
// Notes: Tick period is divisor plus one clocks
`timescale 1ns/100ps
`default_nettype none
module ursb_baud
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] count;
  // ==========================================================
  // Reload on expiry, one tick per reload
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'h0000)
    begin
      count <= divisor; // [RL16] [RL17]
      tick <= 1'b1;
    end
    else
    begin
      count <= count - 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> ursb_params.svh
// Purpose: Constants for the serial receiver status and baud block
// Assumes: 32-bit AHB-Lite register words, byte offsets below
// Notes: Included by the top, checker and bench files of the block
`ifndef URSB_PARAMS_SVH
`define URSB_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define URSB_OFS_MODE 8'h00
`define URSB_OFS_STAT 8'h04
`define URSB_OFS_RXD 8'h08
`define URSB_OFS_TXD 8'h0c
`define URSB_OFS_BAUD 8'h10
`define URSB_OFS_IRQS 8'h14
`define URSB_OFS_IRQM 8'h18
// ==========================================================
// Mode register fields
`define URSB_MODE_STOP 0
`define URSB_MODE_PDLO 1
`define URSB_MODE_PDHI 2
`define URSB_MODE_LOOP 3
`define URSB_MODE_TXEN 4
// Status register fields
`define URSB_STA_AVAIL 0
`define URSB_STA_FRAME_ERR_FLAG 2
`define URSB_STA_PARITY_ERR_FLAG 3
`define URSB_STA_IDLE 4
`define URSB_STA_ADDR_DETECT_ENABLE 5
`define URSB_STA_ISEL 6
`define URSB_STA_TXBUSY 8
// Interrupt status and mask fields
`define URSB_IRQ_RX 0
`define URSB_IRQ_ERR 1
`define URSB_IRQ_TX 2
// ==========================================================
// Data/parity select codes
`define URSB_PD_8N 2'b00
`define URSB_PD_8E 2'b01
`define URSB_PD_8O 2'b10
`define URSB_PD_9N 2'b11
// ==========================================================
// Reset values and bit timing
`define URSB_RST_MODE 5'h00
`define URSB_RST_BAUD 16'h0000
`define URSB_RST_IRQM 3'h0
`define URSB_TICKS_MID 4'h7
`define URSB_TICKS_END 4'hf
`endif

// >>> ursb_peer.sv
// Purpose: Remote serial transmitter on the receive line
// Assumes: Mark level is high between characters
// Notes: Bit time in ns comes from the caller, fast or slow
`timescale 1ns/100ps
`default_nettype none
module ursb_peer
(
  output logic line
);
  // ==========================================================
  // Mark until asked
  initial line = 1'b1;
  // Start bit, bits LSB first, then mark again
  task automatic frame(input logic [15:0] bits, input int n, input int bt);
    line = 1'b0;
    #(bt);
    for (int i = 0; i < n; i++)
    begin
      line = bits[i];
      #(bt);
    end
    line = 1'b1;
  endtask
  // Steady level, for breaks and silence
  task automatic hold(input logic lvl, input int t);
    line = lvl;
    #(t);
  endtask
endmodule
`default_nettype wire

// >>> ursb_pkg.sv
// Purpose: Types for the serial receiver status and baud block
// Assumes: Nothing beyond the parameter header
// Notes: Receive state machine states only
package ursb_pkg;
  // ==========================================================
  // Receiver states
  typedef enum logic [2:0] {
    URSB_RX_IDLE,
    URSB_RX_START,
    URSB_RX_DATA,
    URSB_RX_PAR,
    URSB_RX_STOP,
    URSB_RX_WAIT_HIGH
  } ursb_rx_state_t;
endpackage

// >>> ursb_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to hclk
// Notes: Output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ursb_sync
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // ==========================================================
  // Chain; the line idles high, so reset to one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule
`default_nettype wire

// >>> ursb_top.sv
// Purpose: Serial receiver status flags, baud generator, loopback, AHB-Lite regs
// Assumes: hclk is the instruction clock; single-word AHB-Lite transfers
// Notes: One-word receive holding register carries its own error flags
`timescale 1ns/100ps
`default_nettype none
`include "ursb_params.svh"
// Functional notes
// RL1: Stop bit sampled low sets the framing error flag.
// RL2: With two stop bits, either low sets the framing error flag.
// RL3: Framing error is read-only, stored with each word, reset clears it.
// RL4: Odd or even parity mismatch sets the parity error flag.
// RL5: Parity error is read-only, stored with each word, reset clears it.
// RL6: Idle flag low from start detect until stop completes, else high.
// RL7: Character length follows data/parity select and stop select.
// RL8: Long break ends after one character: zeros, framing error, data available.
// RL9: After a low stop bit, wait for a high line before new start.
// RL10: Break stored as zero word with framing error; idle already high.
// RL11: Address detect in 9-bit mode marks ninth-bit-one words as addresses.
// RL12: In address detect, interrupt select ignored; interrupt on ninth bit set.
// RL13: Loopback feeds transmit into receiver, pin ignored, transmit still drives.
// RL14: Software sets mode, then loopback, then enables transmit.
// RL15: Baud divisor is a 16-bit readable and writable value.
// RL16: Bit rate is clock over sixteen times divisor plus one.
// RL17: Divisor counter reloads and ticks; sixteen ticks per bit.
// RL18: Start confirm and bit samples taken mid-bit.
module ursb_top
  import ursb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic irq
);
  // ==========================================================
  // Register state
  logic [4:0] serial_mode_reg;
  logic [15:0] baud_divisor_reg;
  logic addr_detect_enable;
  logic rx_irq_select;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [8:0] rx_hold;
  logic rx_data_available;
  logic frame_err_flag;
  logic parity_err_flag;
  // Data phase bookkeeping
  logic wr_pend;
  logic [7:0] wr_addr;
  // Receiver state
  ursb_rx_state_t rx_state;
  logic [3:0] rx_tc;
  logic [3:0] rx_bitn;
  logic [8:0] rx_sr;
  logic rx_par;
  logic rx_stop_err;
  logic rx_stop_n;
  // Transmitter state
  logic [11:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_tc;
  logic tx_busy;
  // Internal wires
  logic tick;
  logic pin_level;
  logic rx_line;
  // ==========================================================
  // Decode of address phase and data phase
  wire [1:0] data_parity_select = serial_mode_reg[`URSB_MODE_PDHI:`URSB_MODE_PDLO];
  wire stop_bits_select = serial_mode_reg[`URSB_MODE_STOP];
  wire loopback_enable = serial_mode_reg[`URSB_MODE_LOOP];
  wire tx_enable = serial_mode_reg[`URSB_MODE_TXEN];
  wire nine_mode = (data_parity_select == `URSB_PD_9N);
  wire par_mode = (data_parity_select == `URSB_PD_8E) |
                  (data_parity_select == `URSB_PD_8O);
  wire addr_phase = hsel & hready & htrans[1];
  wire rd_take = addr_phase & ~hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hit_hi = (haddr[31:8] == 24'h000000);
  wire rd_rxd = rd_take & a_hit_hi & (a_ofs == `URSB_OFS_RXD);
  wire rd_irqs = rd_take & a_hit_hi & (a_ofs == `URSB_OFS_IRQS);
  wire wr_mode = wr_pend & (wr_addr == `URSB_OFS_MODE);
  wire wr_stat = wr_pend & (wr_addr == `URSB_OFS_STAT);
  wire wr_txd = wr_pend & (wr_addr == `URSB_OFS_TXD);
  wire wr_baud = wr_pend & (wr_addr == `URSB_OFS_BAUD);
  wire wr_irqm = wr_pend & (wr_addr == `URSB_OFS_IRQM);
  // ==========================================================
  // Read multiplexer; unmapped words read zero
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  always_comb
  begin
    stat_word = 32'h00000000;
    stat_word[`URSB_STA_AVAIL] = rx_data_available;
    stat_word[`URSB_STA_FRAME_ERR_FLAG] = frame_err_flag; // [RL3]
    stat_word[`URSB_STA_PARITY_ERR_FLAG] = parity_err_flag; // [RL5]
    stat_word[`URSB_STA_IDLE] = (rx_state == URSB_RX_IDLE) |
                                (rx_state == URSB_RX_WAIT_HIGH); // [RL6] [RL10]
    stat_word[`URSB_STA_ADDR_DETECT_ENABLE] = addr_detect_enable;
    stat_word[`URSB_STA_ISEL] = rx_irq_select;
    stat_word[`URSB_STA_TXBUSY] = tx_busy;
    rd_word = 32'h00000000;
    if (a_hit_hi)
    begin
      case (a_ofs)
        `URSB_OFS_MODE: rd_word = {27'h0000000, serial_mode_reg};
        `URSB_OFS_STAT: rd_word = stat_word;
        `URSB_OFS_RXD: rd_word = {23'h000000, rx_hold};
        `URSB_OFS_BAUD: rd_word = {16'h0000, baud_divisor_reg}; // [RL15]
        `URSB_OFS_IRQS: rd_word = {29'h00000000, irq_status};
        `URSB_OFS_IRQM: rd_word = {29'h00000000, irq_mask};
        default: rd_word = 32'h00000000;
      endcase
    end
  end
  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_phase & hwrite & a_hit_hi;
      wr_addr <= a_ofs;
      if (rd_take)
        hrdata <= rd_word;
    end
  end
  // ==========================================================
  // Software-written control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_mode_reg <= `URSB_RST_MODE;
      baud_divisor_reg <= `URSB_RST_BAUD;
      addr_detect_enable <= 1'b0;
      rx_irq_select <= 1'b0;
      irq_mask <= `URSB_RST_IRQM;
    end
    else
    begin
      if (wr_mode)
        serial_mode_reg <= hwdata[4:0];
      if (wr_baud)
        baud_divisor_reg <= hwdata[15:0]; // [RL15]
      if (wr_stat)
      begin
        addr_detect_enable <= hwdata[`URSB_STA_ADDR_DETECT_ENABLE];
        rx_irq_select <= hwdata[`URSB_STA_ISEL];
      end
      if (wr_irqm)
        irq_mask <= hwdata[2:0];
    end
  end
  // ==========================================================
  // Baud ticks and receive line source
  ursb_baud u_baud
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor(baud_divisor_reg),
    .tick(tick)
  );
  ursb_sync u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(serial_rx_pin),
    .level(pin_level)
  );
  // Transmit output is on hclk already, so it needs no synchroniser
  assign rx_line = loopback_enable ? serial_tx_pin : pin_level; // [RL13]
  // ==========================================================
  // Receiver frame decode
  wire rx_mid = tick & (rx_tc == ((rx_state == URSB_RX_START) ?
                `URSB_TICKS_MID : `URSB_TICKS_END)); // [RL18]
  wire [3:0] rx_nbits = nine_mode ? 4'h9 : 4'h8; // [RL7]
  wire data_last = (rx_bitn == rx_nbits - 4'h1);
  wire stop_last = (rx_stop_n == stop_bits_select); // [RL7]
  wire rx_done = (rx_state == URSB_RX_STOP) & rx_mid & stop_last;
  wire [8:0] rx_word = nine_mode ? rx_sr : {1'b0, rx_sr[8:1]};
  wire par_calc = ^rx_word[7:0] ^ rx_par;
  wire par_bad = par_mode &
                 ((data_parity_select == `URSB_PD_8E) ? par_calc : ~par_calc); // [RL4]
  wire frame_err_flag_now = rx_stop_err | ~rx_line; // [RL1] [RL2]
  wire is_addr = addr_detect_enable & nine_mode; // [RL11]
  wire rx_keep = ~is_addr | rx_word[8]; // [RL11]
  wire rx_load = rx_done & rx_keep;
  wire rx_evt = rx_load & (is_addr | ~rx_irq_select |
                frame_err_flag_now | par_bad); // [RL12]
  // ==========================================================
  // Receiver state machine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state <= URSB_RX_IDLE;
      rx_tc <= 4'h0;
      rx_bitn <= 4'h0;
      rx_sr <= 9'h000;
      rx_par <= 1'b0;
      rx_stop_err <= 1'b0;
      rx_stop_n <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_tc <= rx_mid ? 4'h0 : rx_tc + 4'h1;
      case (rx_state)
        URSB_RX_IDLE:
        begin
          rx_tc <= 4'h0;
          if (!rx_line)
            rx_state <= URSB_RX_START;
        end
        URSB_RX_START:
          if (rx_mid)
          begin
            rx_bitn <= 4'h0;
            rx_state <= rx_line ? URSB_RX_IDLE : URSB_RX_DATA; // [RL18]
          end
        URSB_RX_DATA:
          if (rx_mid)
          begin
            rx_sr <= {rx_line, rx_sr[8:1]};
            rx_bitn <= rx_bitn + 4'h1;
            rx_stop_err <= 1'b0;
            rx_stop_n <= 1'b0;
            if (data_last)
              rx_state <= par_mode ? URSB_RX_PAR : URSB_RX_STOP; // [RL7]
          end
        URSB_RX_PAR:
          if (rx_mid)
          begin
            rx_par <= rx_line;
            rx_state <= URSB_RX_STOP;
          end
        URSB_RX_STOP:
          if (rx_mid)
          begin
            rx_stop_err <= frame_err_flag_now; // [RL2]
            rx_stop_n <= 1'b1;
            if (stop_last)
              rx_state <= rx_line ? URSB_RX_IDLE : URSB_RX_WAIT_HIGH; // [RL9]
          end
        URSB_RX_WAIT_HIGH:
          if (rx_line)
            rx_state <= URSB_RX_IDLE; // [RL9] [RL10]
        default:
          rx_state <= URSB_RX_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Receive holding word with its own error flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_hold <= 9'h000;
      rx_data_available <= 1'b0;
      frame_err_flag <= 1'b0; // [RL3]
      parity_err_flag <= 1'b0; // [RL5]
    end
    else if (rx_load)
    begin
      // A break arrives here as zeros with the framing flag set
      rx_hold <= rx_word; // [RL8] [RL10]
      rx_data_available <= 1'b1; // [RL8]
      frame_err_flag <= frame_err_flag_now; // [RL1] [RL3] [RL8]
      parity_err_flag <= par_bad; // [RL4] [RL5]
    end
    else if (rd_rxd)
      rx_data_available <= 1'b0;
  end
  // ==========================================================
  // Transmitter; frame laid out LSB first, idle line high
  wire tx_start = wr_txd & tx_enable & ~tx_busy;
  wire tx_parb = ^hwdata[7:0] ^ (data_parity_select == `URSB_PD_8O);
  wire tx_b8 = nine_mode ? hwdata[8] : (par_mode ? tx_parb : 1'b1);
  wire [3:0] tx_len = ((data_parity_select == `URSB_PD_8N) ? 4'h9 : 4'ha) +
                      {3'b000, stop_bits_select} + 4'h1; // [RL7]
  wire tx_bit_end = tick & (tx_tc == `URSB_TICKS_END);
  wire tx_last = tx_busy & tx_bit_end & (tx_left == 4'h1);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_tc <= 4'h0;
      tx_busy <= 1'b0;
    end
    else if (tx_start)
    begin
      tx_shift <= {2'b11, tx_b8, hwdata[7:0], 1'b0};
      tx_left <= tx_len;
      tx_tc <= 4'h0;
      tx_busy <= 1'b1;
    end
    else if (tx_busy & tick)
    begin
      tx_tc <= tx_tc + 4'h1; // [RL17]
      if (tx_bit_end)
      begin
        tx_shift <= {1'b1, tx_shift[11:1]};
        tx_left <= tx_left - 4'h1;
        tx_busy <= ~tx_last;
      end
    end
  end
  // Pin always follows the shifter, loopback or not
  assign serial_tx_pin = tx_shift[0]; // [RL13]
  // ==========================================================
  // Sticky interrupt status; a new event beats the read clear
  wire [2:0] irq_set = {tx_last, rx_load & (frame_err_flag_now | par_bad), rx_evt}; // [RL8] [RL12]
  wire [2:0] next_irq_status = (rd_irqs ? 3'h0 : irq_status) | irq_set;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// >>> ursb_top_chk.sv
// Purpose: Port checks for the serial status block
// Assumes: One clock, single-word bus transfers
// Notes: Shadows follow mode, baud and mask writes
`timescale 1ns/100ps
`default_nettype none
`include "ursb_params.svh"
module ursb_top_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Shadows; data lands one edge after the address phase
  wire take = hsel & hready & htrans[1];
  wire hit = haddr[31:8] == 24'h0;
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic [4:0] mode_sh;
  logic [15:0] baud_sh;
  logic [2:0] mask_sh;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      mode_sh <= `URSB_RST_MODE;
      baud_sh <= `URSB_RST_BAUD;
      mask_sh <= `URSB_RST_IRQM;
    end
    else
    begin
      wr_pend <= take & hwrite & hit;
      wr_ofs <= haddr[7:0];
      if (wr_pend && wr_ofs == `URSB_OFS_MODE)
        mode_sh <= hwdata[4:0];
      if (wr_pend && wr_ofs == `URSB_OFS_BAUD)
        baud_sh <= hwdata[15:0];
      if (wr_pend && wr_ofs == `URSB_OFS_IRQM)
        mask_sh <= hwdata[2:0];
    end
  end
  // ==========================================================
  // Address phases of reads and writes
  sequence s_rd(logic [7:0] ofs);
    take && !hwrite && haddr == {24'h0, ofs};
  endsequence
  sequence s_wr(logic [7:0] ofs);
    take && hwrite && haddr == {24'h0, ofs};
  endsequence
  // Past shadow: a read right behind a write still sees the old value
  a_baud_readback: assert property (
    s_rd(`URSB_OFS_BAUD) |=> hrdata == {16'h0, $past(baud_sh)}) else $error("baud readback");
  a_mode_readback: assert property (
    s_rd(`URSB_OFS_MODE) |=> hrdata == {27'h0, $past(mode_sh)}) else $error("mode readback");
  a_unmapped_zero: assert property (
    take && !hwrite && !hit |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_resp_okay: assert property (hreadyout && !hresp) else $error("bus response not okay");
  a_rdata_hold: assert property (
    !(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  a_irq_masked: assert property (mask_sh == 3'h0 |-> !irq) else $error("masked irq");
  a_irq_clear: assert property (
    s_rd(`URSB_OFS_IRQS) |=> !irq) else $error("irq kept after clear");
  a_tx_start: assert property (
    s_wr(`URSB_OFS_TXD) ##1 (mode_sh[4] && baud_sh == 16'h1) |-> ##[1:100] !serial_tx_pin)
    else $error("no start bit");
endmodule
bind ursb_top ursb_top_chk i_chk
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin), .irq(irq)
);
`default_nettype wire

// >>> ursb_top_tb.sv
// Purpose: Self-checking bench for the serial status block
// Assumes: Zero wait bus; peer sets line timing
// Notes: A queue model predicts each stored word, flag and event
`timescale 1ns/100ps
`default_nettype none
`include "ursb_params.svh"
`define CHK(g, e) \
  begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module ursb_top_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_line, tx_line, irq;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  logic [1:0] htrans;
  logic [2:0] mask;
  int n_errors, num_checks, seed, exp_q[$];
  logic [7:0] ofs[6] = '{`URSB_OFS_MODE, `URSB_OFS_BAUD, `URSB_OFS_STAT,
    `URSB_OFS_IRQM, `URSB_OFS_RXD, `URSB_OFS_IRQS};
  logic [31:0] rstv[6] = '{32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0};
  // Fields: ninth bit, addr detect, irq select, error, data/parity, two stops
  logic [7:0] cfg[12] = '{8'h00, 8'h02, 8'h0a, 8'h04, 8'h0d, 8'h11, 8'h10, 8'h06,
    8'h20, 8'h66, 8'he6, 8'h30};
  ursb_top i_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_rx_pin(rx_line),
    .serial_tx_pin(tx_line), .irq(irq)
  );
  ursb_peer i_peer
  (
    .line(rx_line)
  );
  // ==========================================================
  // Clock and watchdog
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    #2000000;
    n_errors++;
    results();
  end
  task automatic results();
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Bus master: hold each phase until ready is seen
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, {24'h0, a}, 32'h0);
  endtask
  // ==========================================================
  // One character: predict, send, then read flags, word and events
  task automatic rx_case(input logic [7:0] c, input logic [8:0] dd, input int b);
    logic [15:0] bits;
    logic keep;
    int n;
    int e;
    n = (c[2:1] == `URSB_PD_9N) ? 9 : 8;
    if (c[6])
      dd[8] = c[7];
    bits = {7'h0, dd} & ((16'h1 << n) - 16'h1);
    if (c[2:1] == `URSB_PD_8E || c[2:1] == `URSB_PD_8O)
    begin
      bits[n] = ^dd[7:0] ^ (c[2:1] == `URSB_PD_8O) ^ (c[4:3] == 2'd1);
      n++;
    end
    bits[n] = (c[4:3] != 2'd2);
    bits[n + 1] = 1'b1;
    n += c[0] ? 2 : 1;
    keep = !(c[6] && !dd[8]);
    e = {19'h0, c[4:3] != 2'd0, c[6] || !c[5] || c[4:3] != 2'd0, c[4:3] == 2'd1,
      c[4:3] == 2'd2, (c[2:1] == `URSB_PD_9N) & dd[8], dd[7:0]};
    if (keep)
      exp_q.push_back(e);
    wr(`URSB_OFS_BAUD, b);
    wr(`URSB_OFS_MODE, {29'h0, c[2:0]});
    wr(`URSB_OFS_STAT, {25'h0, c[5], c[6], 5'h0});
    wr(`URSB_OFS_IRQM, {29'h0, mask});
    fork
      i_peer.frame(bits, n, 800 * (b + 1));
      begin
        cyc(24 * (b + 1));
        rd(`URSB_OFS_STAT);
        `CHK(r[4], 1'b0)
      end
    join
    cyc(10);
    e = keep ? exp_q.pop_front() : 0;
    rd(`URSB_OFS_STAT);
    `CHK(r[4:0], {1'b1, e[10:9], 1'b0, keep})
    if (keep)
    begin
      rd(`URSB_OFS_RXD);
      `CHK(r, {23'h0, e[8:0]})
    end
    `CHK(irq, |(e[12:11] & mask[1:0]))
    rd(`URSB_OFS_IRQS);
    `CHK(r[2:0], {1'b0, e[12:11]})
    `CHK(irq, 1'b0)
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hresetn = 1'b0;
    seed = 32'hf6f6f2cf;
    cyc(2);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ofs[i]);
      `CHK(r, rstv[i])
    end
    // Status flags ignore writes; unmapped places read zero
    wr(`URSB_OFS_STAT, 32'hffffffff);
    rd(`URSB_OFS_STAT);
    `CHK(r, 32'h70)
    bus(1'b1, 32'h100, 32'hffffffff);
    bus(1'b0, 32'h100, 32'h0);
    `CHK(r, 32'h0)
    rd(8'h1c);
    `CHK(r, 32'h0)
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 32'hffff : $random(seed);
      wr(`URSB_OFS_BAUD, v);
      rd(`URSB_OFS_BAUD);
      `CHK(r, {16'h0, v[15:0]})
    end
    // Mid-run reset: a large divisor only reloads on expiry, so restart the counter
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    rd(`URSB_OFS_BAUD);
    `CHK(r, 32'h0)
    for (int i = 0; i < 12; i++)
    begin
      v = $random(seed);
      mask = 3'(i);
      rx_case(cfg[i], v[8:0], i % 3);
    end
    // Long break: one zero word, then nothing while the line stays low
    wr(`URSB_OFS_BAUD, 32'h1);
    wr(`URSB_OFS_MODE, 32'h0);
    fork
      i_peer.hold(1'b0, 16 * 1600);
      begin
        cyc(12 * 32);
        rd(`URSB_OFS_STAT);
        `CHK(r[4:0], 5'b10101)
        rd(`URSB_OFS_RXD);
        `CHK(r, 32'h0)
        rd(`URSB_OFS_IRQS);
        `CHK(r[1:0], 2'b11)
      end
    join
    i_peer.hold(1'b1, 20 * 1600);
    rd(`URSB_OFS_STAT);
    `CHK(r[0], 1'b0)
    rx_case(8'h00, 9'h0a5, 1);
    // Loopback with the far line low: the echo must still be clean
    mask = 3'h0;
    wr(`URSB_OFS_IRQM, 32'h0);
    wr(`URSB_OFS_STAT, 32'h0);
    wr(`URSB_OFS_MODE, 32'h0);
    wr(`URSB_OFS_MODE, 32'h8);
    wr(`URSB_OFS_MODE, 32'h18);
    i_peer.hold(1'b0, 0);
    v = $random(seed);
    wr(`URSB_OFS_TXD, {24'h0, v[7:0]});
    cyc(12 * 32);
    rd(`URSB_OFS_RXD);
    `CHK(r, {24'h0, v[7:0]})
    rd(`URSB_OFS_IRQS);
    `CHK(r[2:0], 3'b101)
    i_peer.hold(1'b1, 1600);
    wr(`URSB_OFS_MODE, 32'h0);
    results();
  end
endmodule
`default_nettype wire
